// >>> hdl/fpc_map.svh
// timing constants for the flyback pwm protection core
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH
`define FPC_CLK_PERIOD_NS 40
`define FPC_BLANK_NS 250
`define FPC_FAST_OVERCURRENT_TRIP_DELAY_NS 100
`define FPC_SCP_DELAY_MS 70
// least time rounds up
`define FPC_BLANK_CYC ((`FPC_BLANK_NS + `FPC_CLK_PERIOD_NS - 1) / `FPC_CLK_PERIOD_NS)
// longest time rounds down
`define FPC_FAST_OVERCURRENT_TRIP_CYC (`FPC_FAST_OVERCURRENT_TRIP_DELAY_NS / `FPC_CLK_PERIOD_NS)
`define FPC_SCP_CYC (`FPC_SCP_DELAY_MS * 1000000 / `FPC_CLK_PERIOD_NS)
`endif

// >>> hdl/fpc_pkg.sv
// types for the flyback pwm protection core
package fpc_pkg;
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_RUN = 4'h2,
        ST_HICCUP = 4'h4,
        ST_LATCHED = 4'h8
    } fpc_state_e;

    typedef struct packed {
        logic peak_reached;
        logic cycle_current_limit;
        logic fast_overcurrent_trip;
    } fpc_sense_s;

    typedef struct packed {
        logic fb_high;
        logic fb_low;
        logic supply_on;
        logic supply_off;
        logic supply_maintain;
        logic pin_fault;
        logic protect_low;
        logic protect_high;
    } fpc_prot_s;
endpackage

// >>> hdl/fpc_core.sv
// control core: pulse generation, blanking and protection state
// Functional notes
// R1 - a gate pulse starts at every oscillator cycle start while switching is allowed.
// R2 - the pulse ends when the peak-current comparator reports the feedback level reached.
// R3 - for 250ns after turn-on the current comparators are ignored and the gate stays on.
// R4 - a fast overcurrent trip ends the pulse within about 100ns.
// R5 - feedback high held for 70ms enters short-circuit protection.
// R6 - in short-circuit protection switching stops until supply-off, then start-up retries.
// R7 - feedback low suppresses the gate at once and stops regulation pulses.
// R8 - switching starts only after supply-on and stops when supply-off asserts.
// R9 - with regulation stopped and supply-maintain asserted, pulses are issued anyway.
// R10 - the cycle current limit comparator ends the pulse on every cycle.
// R11 - a pin fault disables all switching.
// R12 - protect-pin low trip latches, protect-pin high trip recovers by itself.
// R13 - once latched the gate stays off whatever the other inputs do.
// R14 - the latch clears only on full supply collapse, i.e. the block reset.
// R15 - the short-circuit delay counter restarts when feedback high drops early.
// R16 - blanking and protection delays are counted on the system clock.
`timescale 1ns/1ps
`include "fpc_map.svh"

module fpc_core #(
    parameter int SCP_CYC = `FPC_SCP_CYC,
    parameter int BLANK_CYC = `FPC_BLANK_CYC,
    parameter int FAST_OVERCURRENT_TRIP_CYC = `FPC_FAST_OVERCURRENT_TRIP_CYC
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic osc_start,
    input wire fpc_pkg::fpc_sense_s sense,
    input wire fpc_pkg::fpc_prot_s prot,
    output logic gate_drive,
    output logic overload_shutdown,
    output logic latch_fault,
    output logic switching_allowed
);

    ////////////////////////////////////////////////////////////////////////
    localparam int SCW = $clog2(SCP_CYC + 1);
    localparam int BW = $clog2(BLANK_CYC + 1);

    fpc_pkg::fpc_state_e state_ff;
    fpc_pkg::fpc_state_e nxt_state;
    logic gate_ff;
    logic [BW-1:0] blank_ff;
    logic [SCW-1:0] scp_ff;
    logic [SCW-1:0] nxt_scp;
    logic fast_overcurrent_trip_ff;
    logic nxt_gate;
    logic [BW-1:0] nxt_blank;
    // one bit wider than the blanking count so the checks can see past it
    localparam int OW = BW + 1;
    logic [OW-1:0] on_time_ff;

    // state compare shared by the run, off, hiccup and latched flag decodes of the state register
    function automatic logic in_state(fpc_pkg::fpc_state_e cur,
        fpc_pkg::fpc_state_e want);
        return cur == want;
    endfunction

    wire blanking = gate_ff && (blank_ff != '0);
    wire scp_expired = prot.fb_high && (scp_ff == SCW'(SCP_CYC - 1));
    wire run_state = in_state(state_ff, fpc_pkg::ST_RUN);
    wire off_state = in_state(state_ff, fpc_pkg::ST_OFF);
    // maintain pulses are allowed while feedback low holds regulation off
    wire pulse_allowed = run_state && !prot.pin_fault && !prot.protect_high
        && !prot.supply_off && (!prot.fb_low || prot.supply_maintain);
    // fast_overcurrent_trip is one cycle: the 100ns figure allows FAST_OVERCURRENT_TRIP_CYC - 1 = 1 stage only
    wire current_stop = sense.peak_reached || sense.cycle_current_limit
        || fast_overcurrent_trip_ff;
    wire gate_kill = !pulse_allowed
        || (prot.fb_low && !prot.supply_maintain);

    assign switching_allowed = pulse_allowed;
    assign gate_drive = gate_ff;
    assign overload_shutdown = in_state(state_ff, fpc_pkg::ST_HICCUP);
    assign latch_fault = in_state(state_ff, fpc_pkg::ST_LATCHED);

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            fpc_pkg::ST_OFF:
            begin
                if (prot.supply_on && !prot.supply_off) // see R8
                    nxt_state = fpc_pkg::ST_RUN;
            end
            fpc_pkg::ST_RUN:
            begin
                if (prot.supply_off) // see R8
                    nxt_state = fpc_pkg::ST_OFF;
                else if (scp_expired) // see R5
                    nxt_state = fpc_pkg::ST_HICCUP;
            end
            fpc_pkg::ST_HICCUP:
            begin
                if (prot.supply_off) // see R6
                    nxt_state = fpc_pkg::ST_OFF;
            end
            fpc_pkg::ST_LATCHED:
                nxt_state = fpc_pkg::ST_LATCHED; // see R13
            default:
                nxt_state = fpc_pkg::ST_OFF;
        endcase
        // low protect trip latches from any state, cleared only by reset
        if (prot.protect_low) // see R12
            nxt_state = fpc_pkg::ST_LATCHED;
    end

    // counter restarts whenever feedback high drops or the state is not ST_RUN
    assign nxt_scp = (prot.fb_high && run_state) ? // see R15
        (scp_expired ? '0 : scp_ff + SCW'(1)) : '0;

    always_comb
    begin
        nxt_gate = gate_ff;
        nxt_blank = blank_ff;
        if (gate_kill) // see R7
            nxt_gate = 1'b0;
        else if (!gate_ff && osc_start) // see R1
        begin
            nxt_gate = 1'b1;
            nxt_blank = BW'(BLANK_CYC - 1); // see R16
        end
        else if (blanking) // see R3
            nxt_blank = blank_ff - BW'(1);
        else if (gate_ff && current_stop) // see R2
            nxt_gate = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // srst stands for full supply collapse, the only latch release
    always_ff @(posedge clk_sys)
    begin
        if (srst) // see R14
        begin
            state_ff <= fpc_pkg::ST_OFF;
            gate_ff <= 1'b0;
            blank_ff <= '0;
            scp_ff <= '0;
            fast_overcurrent_trip_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            gate_ff <= nxt_gate;
            blank_ff <= nxt_blank;
            scp_ff <= nxt_scp;
            fast_overcurrent_trip_ff <= sense.fast_overcurrent_trip; // see R4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // on-time count for the checks only; it saturates so a stuck gate
    // cannot wrap back into the blanking range
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            on_time_ff <= '0;
        else if (!gate_ff)
            on_time_ff <= '0;
        else if (on_time_ff != '1)
            on_time_ff <= on_time_ff + OW'(1);
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    blank_hold_a: assert property ( // see R3
        $rose(gate_ff) ##0 pulse_allowed[*2] |=> gate_ff)
        else $error("gate dropped inside blanking");
    peak_end_a: assert property ( // see R2
        gate_ff && !blanking && sense.peak_reached && !osc_start
        |=> !gate_ff)
        else $error("gate not ended on peak current");
    ocp_end_a: assert property ( // see R10
        gate_ff && !blanking && sense.cycle_current_limit |=> !gate_ff)
        else $error("gate not ended on current limit");
    fast_overcurrent_trip_end_a: assert property ( // see R4
        gate_ff && !blanking && sense.fast_overcurrent_trip |-> ##[1:2]
        !gate_ff)
        else $error("fast trip did not end gate");
    fb_low_a: assert property ( // see R7
        prot.fb_low && !prot.supply_maintain |=> !gate_ff)
        else $error("gate on while feedback low");
    start_a: assert property ( // see R1
        pulse_allowed && !gate_ff && osc_start && !(prot.fb_low
        && !prot.supply_maintain) |=> gate_ff)
        else $error("pulse not started");
    supply_gate_a: assert property ( // see R8
        prot.supply_off |=> !gate_ff)
        else $error("gate on after supply off");
    fault_off_a: assert property ( // see R11
        prot.pin_fault |=> !gate_ff)
        else $error("gate on with pin fault");
    latch_a: assert property ( // see R13
        latch_fault |=> latch_fault && !gate_ff)
        else $error("latch released or gate on");
    latch_set_a: assert property ( // see R12
        prot.protect_low |=> latch_fault)
        else $error("low protect trip not latched");
    hiccup_a: assert property ( // see R6
        overload_shutdown && !prot.supply_off && !prot.protect_low
        |=> overload_shutdown && !gate_ff)
        else $error("hiccup left without supply off");
    scp_reset_a: assert property ( // see R15
        !prot.fb_high |=> scp_ff == '0)
        else $error("short-circuit counter not restarted");

    ////////////////////////////////////////////////////////////////////////
    // pulse timing: blanking length and what may end or start a pulse
    min_on_a: assert property ( // see R16
        gate_ff && pulse_allowed
        && on_time_ff < OW'(BLANK_CYC - 1) |=> gate_ff)
        else $error("gate shorter than blanking time");
    blank_load_a: assert property ( // see R3
        $rose(gate_ff) |-> blank_ff == BW'(BLANK_CYC - 1))
        else $error("blanking not loaded at turn-on");
    blank_ignore_a: assert property ( // see R3
        blanking && pulse_allowed |=> gate_ff)
        else $error("gate dropped while blanked");
    hold_on_a: assert property ( // see R2
        gate_ff && !blanking && pulse_allowed && !sense.peak_reached
        && !sense.cycle_current_limit && !fast_overcurrent_trip_ff |=> gate_ff)
        else $error("gate ended with no end condition");
    no_start_a: assert property ( // see R1
        !gate_ff && !osc_start |=> !gate_ff)
        else $error("gate started outside cycle start");
    fast_overcurrent_trip_stage_a: assert property ( // see R4
        fast_overcurrent_trip_ff == $past(sense.fast_overcurrent_trip))
        else $error("fast trip stage lost");
    maintain_a: assert property ( // see R9
        run_state && prot.fb_low && prot.supply_maintain && !gate_ff
        && osc_start && !prot.pin_fault && !prot.protect_high
        && !prot.supply_off |=> gate_ff)
        else $error("no maintain pulse");

    ////////////////////////////////////////////////////////////////////////
    // protection state and the permission it gives
    scp_enter_a: assert property ( // see R5
        scp_expired && run_state && !prot.supply_off && !prot.protect_low
        |=> overload_shutdown)
        else $error("short-circuit delay did not stop switching");
    scp_count_a: assert property ( // see R15
        run_state && prot.fb_high && !scp_expired
        |=> scp_ff == $past(scp_ff) + SCW'(1))
        else $error("short-circuit counter skipped");
    scp_idle_a: assert property ( // see R15
        !run_state |=> scp_ff == '0)
        else $error("short-circuit counter ran outside run");
    hiccup_exit_a: assert property ( // see R6
        overload_shutdown && prot.supply_off && !prot.protect_low
        |=> off_state)
        else $error("hiccup did not wait for restart");
    hiccup_block_a: assert property ( // see R6
        overload_shutdown |-> !switching_allowed)
        else $error("switching allowed in hiccup");
    off_gate_a: assert property ( // see R8
        off_state |-> !gate_ff)
        else $error("gate on in supply lockout");
    supply_block_a: assert property ( // see R8
        prot.supply_off |-> !switching_allowed)
        else $error("switching allowed at supply off");
    low_block_a: assert property ( // see R7
        prot.fb_low && !prot.supply_maintain |-> !switching_allowed)
        else $error("regulation allowed with feedback low");
    pin_block_a: assert property ( // see R11
        prot.pin_fault |-> !switching_allowed)
        else $error("switching allowed with pin fault");
    auto_trip_a: assert property ( // see R12
        prot.protect_high |=> !gate_ff)
        else $error("gate on with high protect trip");
    auto_block_a: assert property ( // see R12
        prot.protect_high |-> !switching_allowed)
        else $error("switching allowed with high protect trip");
    latch_block_a: assert property ( // see R13
        latch_fault |-> !switching_allowed)
        else $error("switching allowed while latched");
    latch_supply_a: assert property ( // see R14
        latch_fault && prot.supply_off |=> latch_fault)
        else $error("latch released by supply dip");
    state_code_a: assert property ( // see R13
        $onehot(state_ff))
        else $error("state code not one-hot");

    pulse_c: cover property ($rose(gate_ff) ##[1:20] $fell(gate_ff));
    hiccup_c: cover property ($rose(overload_shutdown));
    latch_c: cover property ($rose(latch_fault));
    maintain_c: cover property (prot.fb_low && prot.supply_maintain
        && $rose(gate_ff));
    scp_restart_c: cover property (run_state && prot.fb_high
        ##1 !prot.fb_high);

endmodule // fpc_core

// >>> test/fpc_sense_model.sv
// sense comparator model: current ramps while the switch conducts
`timescale 1ns/1ps
module fpc_sense_model (
    input wire logic clk_sys,
    input wire logic gate_drive,
    input wire logic [7:0] ramp_len,
    output logic peak_reached
);
    logic [7:0] on_cnt_ff;
    always_ff @(posedge clk_sys)
    begin
        on_cnt_ff <= gate_drive ? on_cnt_ff + 8'h01 : 8'h00;
    end
    // held until the switch opens, like a real comparator on a ramp
    assign peak_reached = gate_drive && (on_cnt_ff >= ramp_len);
endmodule // fpc_sense_model

// >>> test/flyback_pwm_protection_ctrl_tb_top.sv
// self-checking bench for the flyback pwm control core
`timescale 1ns/1ps
module flyback_pwm_protection_ctrl_tb_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic osc_start = 1'b0;
    logic cur_lim = 1'b0;
    logic fast = 1'b0;
    logic peak;
    logic [7:0] ramp_len = 8'h00;
    fpc_pkg::fpc_prot_s prot = '0;
    fpc_pkg::fpc_sense_s sense;
    logic gate_drive, overload_shutdown, latch_fault, switching_allowed;
    int errors = 0;
    int n_compared = 0;
    int seed = 32'h8f67;
    int cycles = 0;
    assign sense = {peak, cur_lim, fast};
    always #20 clk_sys = ~clk_sys;
    fpc_core #(.SCP_CYC(20)) u_fpc_core (.clk_sys(clk_sys), .srst(srst),
        .osc_start(osc_start), .sense(sense), .prot(prot),
        .gate_drive(gate_drive), .overload_shutdown(overload_shutdown),
        .latch_fault(latch_fault), .switching_allowed(switching_allowed));
    fpc_sense_model u_fpc_sense_model (.clk_sys(clk_sys),
        .gate_drive(gate_drive), .ramp_len(ramp_len), .peak_reached(peak));
    ////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // on-time: seven blanked cycles at least, else stop index plus one
    function automatic int ontime(int v);
        return (v + 1 > 7 ? v + 1 : 7);
    endfunction
    task automatic pulse(input int len, input int lim, input int ft,
        input bit ok);
        int n;
        int e;
        n = 0;
        e = ontime(len);
        e = ontime(lim) < e ? ontime(lim) : e;
        e = ontime(ft + 1) < e ? ontime(ft + 1) : e;
        ramp_len = len[7:0];
        osc_start = 1'b1;
        cyc(1);
        osc_start = 1'b0;
        for (int i = 0; i < 40; i++)
        begin
            n += (gate_drive === 1'b1);
            cur_lim = cur_lim | (i == lim);
            fast = fast | (i == ft);
            cyc(1);
        end
        cur_lim = 1'b0;
        fast = 1'b0;
        chk("gate on-time", n, ok ? e : 0);
    endtask
    task automatic supply_dip();
        prot.supply_on = 1'b0;
        prot.supply_off = 1'b1;
        cyc(1);
        prot.supply_off = 1'b0;
        prot.supply_on = 1'b1;
        cyc(2);
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            print_verdict();
        end
    end
    initial
    begin
        cyc(16);
        srst = 1'b0;
        pulse(9, 99, 99, 0);
        prot.supply_on = 1'b1;
        cyc(2);
        repeat (6) pulse($unsigned($random(seed)) % 20, 99, 99, 1);
        pulse(30, 0, 99, 1);
        pulse(30, 99, 12, 1);
        prot.fb_low = 1'b1;
        pulse(9, 99, 99, 0);
        prot.supply_maintain = 1'b1;
        pulse(9, 99, 99, 1);
        prot = '{supply_on: 1'b1, pin_fault: 1'b1, default: 1'b0};
        pulse(9, 99, 99, 0);
        prot.pin_fault = 1'b0;
        prot.protect_high = 1'b1;
        pulse(9, 99, 99, 0);
        prot.protect_high = 1'b0;
        pulse(9, 99, 99, 1);
        prot.fb_high = 1'b1;
        cyc(15);
        prot.fb_high = 1'b0;
        cyc(1);
        prot.fb_high = 1'b1;
        cyc(15);
        chk("shutdown early", overload_shutdown, 1'b0);
        cyc(10);
        chk("shutdown", overload_shutdown, 1'b1);
        prot.fb_high = 1'b0;
        pulse(9, 99, 99, 0);
        supply_dip();
        chk("shutdown left", overload_shutdown, 1'b0);
        pulse(9, 99, 99, 1);
        prot.protect_low = 1'b1;
        cyc(1);
        prot.protect_low = 1'b0;
        cyc(2);
        chk("latched", latch_fault, 1'b1);
        chk("allowed latched", switching_allowed, 1'b0);
        supply_dip();
        chk("latch held", latch_fault, 1'b1);
        pulse(9, 0, 99, 0);
        srst = 1'b1;
        cyc(1);
        srst = 1'b0;
        cyc(2);
        chk("latch cleared", latch_fault, 1'b0);
        chk("allowed again", switching_allowed, 1'b1);
        pulse(9, 99, 99, 1);
        print_verdict();
    end
endmodule // flyback_pwm_protection_ctrl_tb_top
